// File: hw/lcdxid_defines.vh
/*
 * Constants for the extended instruction decoder of a character LCD controller:
 * register offsets, field positions, opcodes, reset values and timing counts.
 * Assumes it is included by its bare name from the decoder's design file.
 */
`ifndef LCDXID_DEFINES_VH
`define LCDXID_DEFINES_VH

// Register byte offsets on the AHB-Lite slave
`define LX_OFF_INSTR      8'h00
`define LX_OFF_CTRL       8'h04
`define LX_OFF_STATUS     8'h08
`define LX_OFF_ANALOG     8'h0C
`define LX_OFF_OSC        8'h10
`define LX_ADDR_W         8

// Instruction register fields
`define LX_REGSEL_BIT     9
`define LX_RW_BIT         8
`define LX_OPC_HI         7
`define LX_OPC_LO         4
`define LX_ARG_HI         3
`define LX_ARG_LO         0

// Extended set opcodes (upper nibble)
`define LX_OPC_OSC        4'h1
`define LX_OPC_ICON_ADDR  4'h4
`define LX_OPC_PWR        4'h5
`define LX_OPC_FOLLOW     4'h6
`define LX_OPC_CONTR_LO   4'h7
// Function set: 001x xxxx, extended select in bit 0
`define LX_FSET_HI        7
`define LX_FSET_LO        5
`define LX_FSET_CODE      3'h1
`define LX_FSET_EXT_BIT   0

// Argument bit positions
`define LX_ICON_EN_BIT    3
`define LX_BOOST_BIT      2
`define LX_FOLLOW_BIT     3
`define LX_CHI_HI         1
`define LX_CHI_LO         0
`define LX_GAIN_HI        2
`define LX_GAIN_LO        0
`define LX_TRIM_HI        2
`define LX_TRIM_LO        0

// Reset values
`define LX_RST_TRIM       3'h0
`define LX_RST_GAIN       3'h0
`define LX_RST_CHI        2'h0
`define LX_RST_CLO        4'h0
`define LX_RST_ICON_ADDR  4'h0

// Frame rate table in Hz, 2-line mode, low supply column
`define LX_FRAME_HZ_0     9'h07A
`define LX_FRAME_HZ_1     9'h083
`define LX_FRAME_HZ_2     9'h090
`define LX_FRAME_HZ_3     9'h0A1
`define LX_FRAME_HZ_4     9'h0B7
`define LX_FRAME_HZ_5     9'h0DD
`define LX_FRAME_HZ_6     9'h112
`define LX_FRAME_HZ_7     9'h15B

// Execution time of one instruction: 1000 ns at a 50 MHz clock
`define LX_EXEC_CYC       6'h32
`define LX_CNT_W          6
`define LX_CNT_ONE        6'h01
`define LX_CNT_ZERO       6'h00

`define LX_HTRANS_NONSEQ  1'b1
`define LX_HSIZE_WORD     3'h2
`define LX_ZERO32         32'h00000000

`endif

// File: hw/lcdxid_decoder.v
/*
 * Extended instruction decoder of a character LCD controller, with an
 * AHB-Lite slave through which software posts instructions (the parallel
 * instruction port image) and reads back the decoded analogue settings.
 * Assumes a single master doing whole-word single transfers, and that the
 * bias option pins and clock source select are static straps from outside.
 */
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`include "lcdxid_defines.vh"

// Notes on behaviour
// - With clock source select high, trim code picks frame rate 122..347 Hz.
// - Register select and read/write low, opcode 0100, load icon address counter.
// - Icon address decoded only when extended select is one.
// - Icon addresses limited to 00H..0FH, sixteen locations.
// - Opcode 0101: bit3 icon enable, bit2 booster, bits1..0 contrast high.
// - Icon enable one shows icons, zero blanks them.
// - Booster follows its bit, accepted only with both bias pins zero.
// - Six-bit contrast level, any bit updated only with both bias pins zero.
// - Opcode 0110 bit3 follower on/off, accepted only with both bias pins zero.
// - Opcode 0110 bits2..0 gain ratio, accepted only with both bias pins zero.
// - Opcode 0111 loads bits3..0 into contrast level low nibble.
// - Extended table used when extended select is one, normal table otherwise.
module lcdxid_decoder
(
    input  wire        CLK,
    input  wire        RST,
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output reg  [31:0] HRDATA,
    output reg         HREADYOUT,
    output reg         HRESP,
    input  wire        CLOCK_SOURCE_SELECT,
    input  wire        BIAS_OPTION_PIN_A,
    input  wire        BIAS_OPTION_PIN_B,
    output reg         ICON_ENABLE,
    output reg         BOOSTER_ENABLE,
    output reg         FOLLOWER_ENABLE,
    output reg  [2:0]  V0_GAIN_RATIO,
    output reg  [5:0]  CONTRAST_LEVEL,
    output reg  [2:0]  OSC_TRIM_CODE,
    output reg  [8:0]  FRAME_RATE_HZ,
    output reg  [3:0]  ICON_ADDRESS,
    output reg         BUSY_FLAG
);

    localparam ST_IDLE = 2'b01;
    localparam ST_EXEC = 2'b10;

    // Synchronised straps
    wire                  css_sync;
    wire                  bias_a_sync;
    wire                  bias_b_sync;

    // Bus address phase capture
    reg                   wr_pend_r;
    reg                   rd_pend_r;
    reg  [`LX_ADDR_W-1:0] addr_r;

    // Decoder state
    reg  [1:0]            state_r;
    reg  [1:0]            state_nxt;
    reg  [`LX_CNT_W-1:0]  cnt_r;
    reg  [`LX_CNT_W-1:0]  cnt_nxt;
    reg  [9:0]            instr_r;
    reg                   ext_sel_r;
    reg                   icon_sel_r;
    reg  [1:0]            chi_r;
    reg  [3:0]            clo_r;
    reg  [15:0]           rejects_r;

    wire                  css_s;
    wire                  int_follower;
    wire                  addr_phase;
    wire                  instr_wr;
    wire                  instr_go;
    wire [3:0]            opc;
    wire [3:0]            arg;
    wire                  is_cmd;
    wire                  exec_done;
    reg  [8:0]            frame_hz;
    reg  [31:0]           rdata;

    assign css_s        = css_sync;
    // Internal follower option: both bias pins strapped low
    assign int_follower = ~bias_a_sync & ~bias_b_sync;
    assign addr_phase   = HSEL & HREADY & HTRANS[1] & HREADYOUT;
    assign instr_wr     = wr_pend_r & (addr_r == `LX_OFF_INSTR);
    // An instruction posted while busy is dropped and counted
    assign instr_go     = instr_wr & (state_r == ST_IDLE);
    assign opc          = HWDATA[`LX_OPC_HI:`LX_OPC_LO];
    assign arg          = HWDATA[`LX_ARG_HI:`LX_ARG_LO];
    assign is_cmd       = ~HWDATA[`LX_REGSEL_BIT] & ~HWDATA[`LX_RW_BIT];
    assign exec_done    = (state_r == ST_EXEC) & (cnt_r == `LX_CNT_ONE);

    // Straps come from pins; nothing reads the first stage of a synchroniser
    lcdxid_sync u_sync_css
    (
        .clk  (CLK),
        .rst  (RST),
        .din  (CLOCK_SOURCE_SELECT),
        .dout (css_sync)
    );

    lcdxid_sync u_sync_bias_a
    (
        .clk  (CLK),
        .rst  (RST),
        .din  (BIAS_OPTION_PIN_A),
        .dout (bias_a_sync)
    );

    lcdxid_sync u_sync_bias_b
    (
        .clk  (CLK),
        .rst  (RST),
        .din  (BIAS_OPTION_PIN_B),
        .dout (bias_b_sync)
    );

    // Bus slave: zero wait states, always OKAY
    always @(posedge CLK)
    begin
        if (RST)
        begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= `LX_OFF_INSTR;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            HRDATA    <= `LX_ZERO32;
        end
        else
        begin
            // Only whole-word writes reach the registers
            wr_pend_r <= addr_phase & HWRITE & (HSIZE == `LX_HSIZE_WORD);
            rd_pend_r <= addr_phase & ~HWRITE;
            if (addr_phase)
            begin
                addr_r <= HADDR[`LX_ADDR_W-1:0];
            end
            if (addr_phase & ~HWRITE)
            begin
                HRDATA <= rdata;
            end
        end
    end

    always @*
    begin
        rdata = `LX_ZERO32;
        case (HADDR[`LX_ADDR_W-1:0])
            `LX_OFF_INSTR:  rdata = {22'h0, instr_r};
            `LX_OFF_CTRL:   rdata = {31'h0, ext_sel_r};
            `LX_OFF_STATUS: rdata = {rejects_r, 4'h0, bias_b_sync, bias_a_sync, css_sync,
                                     icon_sel_r, ICON_ADDRESS, 3'h0, BUSY_FLAG};
            `LX_OFF_ANALOG: rdata = {20'h0, chi_r, clo_r, V0_GAIN_RATIO,
                                     FOLLOWER_ENABLE, BOOSTER_ENABLE, ICON_ENABLE};
            `LX_OFF_OSC:    rdata = {20'h0, FRAME_RATE_HZ, OSC_TRIM_CODE};
            default:        rdata = `LX_ZERO32;
        endcase
    end

    always @*
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            ST_IDLE:
            begin
                if (instr_go)
                begin
                    state_nxt = ST_EXEC;
                    cnt_nxt   = `LX_EXEC_CYC;
                end
            end
            ST_EXEC:
            begin
                cnt_nxt = cnt_r - `LX_CNT_ONE;
                if (exec_done)
                begin
                    state_nxt = ST_IDLE;
                    cnt_nxt   = `LX_CNT_ZERO;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
                cnt_nxt   = `LX_CNT_ZERO;
            end
        endcase
    end

    always @*
    begin
        case (OSC_TRIM_CODE)
            3'h0:    frame_hz = `LX_FRAME_HZ_0;
            3'h1:    frame_hz = `LX_FRAME_HZ_1;
            3'h2:    frame_hz = `LX_FRAME_HZ_2;
            3'h3:    frame_hz = `LX_FRAME_HZ_3;
            3'h4:    frame_hz = `LX_FRAME_HZ_4;
            3'h5:    frame_hz = `LX_FRAME_HZ_5;
            3'h6:    frame_hz = `LX_FRAME_HZ_6;
            default: frame_hz = `LX_FRAME_HZ_7;
        endcase
    end

    // Dropped posts are counted so software can spot a busy-flag violation
    always @(posedge CLK)
    begin
        if (RST)
        begin
            rejects_r <= 16'h0000;
        end
        else if (instr_wr & ~instr_go)
        begin
            rejects_r <= rejects_r + 16'h0001;
        end
    end

    always @(posedge CLK)
    begin
        if (RST)
        begin
            state_r         <= ST_IDLE;
            cnt_r           <= `LX_CNT_ZERO;
            BUSY_FLAG       <= 1'b0;
            instr_r         <= 10'h000;
            ext_sel_r       <= 1'b0;
            icon_sel_r      <= 1'b0;
            ICON_ADDRESS    <= `LX_RST_ICON_ADDR;
            ICON_ENABLE     <= 1'b0;
            BOOSTER_ENABLE  <= 1'b0;
            FOLLOWER_ENABLE <= 1'b0;
            V0_GAIN_RATIO   <= `LX_RST_GAIN;
            chi_r           <= `LX_RST_CHI;
            clo_r           <= `LX_RST_CLO;
            CONTRAST_LEVEL  <= 6'h00;
            OSC_TRIM_CODE   <= `LX_RST_TRIM;
            FRAME_RATE_HZ   <= `LX_FRAME_HZ_0;
        end
        else
        begin
            state_r        <= state_nxt;
            cnt_r          <= cnt_nxt;
            BUSY_FLAG      <= (state_nxt == ST_EXEC);
            CONTRAST_LEVEL <= {chi_r, clo_r};
            // Frame rate only tracks trim with the internal oscillator selected
            if (css_s)
            begin
                FRAME_RATE_HZ <= frame_hz;
            end
            if (instr_go)
            begin
                instr_r <= HWDATA[9:0];
            end
            // Function set is shared by both tables; it loads the table select from bit 0
            if (instr_go & is_cmd & (HWDATA[`LX_FSET_HI:`LX_FSET_LO] == `LX_FSET_CODE))
            begin
                ext_sel_r <= HWDATA[`LX_FSET_EXT_BIT];
            end
            // Normal-table opcodes fall outside this block and are ignored here
            if (instr_go & is_cmd & ext_sel_r)
            begin
                case (opc)
                    `LX_OPC_OSC:
                    begin
                        if (css_s)
                        begin
                            OSC_TRIM_CODE <= arg[`LX_TRIM_HI:`LX_TRIM_LO];
                        end
                    end
                    `LX_OPC_ICON_ADDR:
                    begin
                        // A nibble cannot leave 00H..0FH
                        ICON_ADDRESS <= arg;
                        icon_sel_r   <= 1'b1;
                    end
                    `LX_OPC_PWR:
                    begin
                        ICON_ENABLE <= arg[`LX_ICON_EN_BIT];
                        if (int_follower)
                        begin
                            BOOSTER_ENABLE <= arg[`LX_BOOST_BIT];
                            chi_r          <= arg[`LX_CHI_HI:`LX_CHI_LO];
                        end
                    end
                    `LX_OPC_FOLLOW:
                    begin
                        if (int_follower)
                        begin
                            FOLLOWER_ENABLE <= arg[`LX_FOLLOW_BIT];
                            V0_GAIN_RATIO   <= arg[`LX_GAIN_HI:`LX_GAIN_LO];
                        end
                    end
                    `LX_OPC_CONTR_LO:
                    begin
                        if (int_follower)
                        begin
                            clo_r <= arg;
                        end
                    end
                    default:
                    begin
                        icon_sel_r <= icon_sel_r;
                    end
                endcase
            end
            // A normal-table address set with bit 7 high moves the counter off icon RAM
            if (instr_go & is_cmd & ~ext_sel_r & HWDATA[7])
            begin
                icon_sel_r <= 1'b0;
            end
        end
    end

endmodule

// Two-flop synchroniser for a pin not timed to CLK; the first stage may
// still be settling, so only the second stage is handed on
module lcdxid_sync
#(
    parameter WIDTH = 1
)
(
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);

    reg  [WIDTH-1:0] meta_r;

    always @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= {WIDTH{1'b0}};
            dout   <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule

// File: verification/lcdxid_assertions.sv
/* Port checker for the extended instruction decoder.
   Assumes straps stay still for several cycles around each instruction. */
module lcdxid_assertions
(
    input wire       CLK,
    input wire       RST,
    input wire       CLOCK_SOURCE_SELECT,
    input wire       BIAS_OPTION_PIN_A,
    input wire       BIAS_OPTION_PIN_B,
    input wire       ICON_ENABLE,
    input wire       BOOSTER_ENABLE,
    input wire       FOLLOWER_ENABLE,
    input wire [2:0] V0_GAIN_RATIO,
    input wire [5:0] CONTRAST_LEVEL,
    input wire [2:0] OSC_TRIM_CODE,
    input wire [8:0] FRAME_RATE_HZ,
    input wire [3:0] ICON_ADDRESS,
    input wire       BUSY_FLAG
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam [71:0] FR_TBL = {9'h15B, 9'h112, 9'h0DD, 9'h0B7, 9'h0A1, 9'h090, 9'h083, 9'h07A};
    wire       bz  = !BIAS_OPTION_PIN_A && !BIAS_OPTION_PIN_B;
    wire       css = CLOCK_SOURCE_SELECT;
    reg  [7:0] busy_cnt_r;
    // Counts busy cycles so the whole execution time is checked, not just its start
    always @(posedge CLK)
        if (RST || !BUSY_FLAG)
            busy_cnt_r <= 8'h00;
        else
            busy_cnt_r <= busy_cnt_r + 8'h01;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_frame_table: assert property (
        !$stable(FRAME_RATE_HZ) |-> FRAME_RATE_HZ == FR_TBL[$past(OSC_TRIM_CODE) * 9 +: 9])
        else $error("frame rate off table");
    a_trim_needs_css: assert property (
        !$stable(OSC_TRIM_CODE) |-> $past(css, 2) || $past(css, 3) || $past(css, 4))
        else $error("trim changed without clock select");
    a_bias_power: assert property (
        !$stable({BOOSTER_ENABLE, FOLLOWER_ENABLE, V0_GAIN_RATIO})
        |-> $past(bz, 2) || $past(bz, 3) || $past(bz, 4))
        else $error("power setting changed with bias pins set");
    a_bias_contrast: assert property (
        !$stable(CONTRAST_LEVEL) |-> $past(bz, 3) || $past(bz, 4) || $past(bz, 5))
        else $error("contrast changed with bias pins set");
    a_decode_edge: assert property (
        !$stable({ICON_ENABLE, BOOSTER_ENABLE, FOLLOWER_ENABLE, V0_GAIN_RATIO,
        OSC_TRIM_CODE, ICON_ADDRESS}) |-> $rose(BUSY_FLAG))
        else $error("setting changed outside an accepted instruction");
    a_contrast_lag: assert property (
        !$stable(CONTRAST_LEVEL) |-> $past(BUSY_FLAG) && !$past(BUSY_FLAG, 2))
        else $error("contrast update not one cycle after busy rise");
    a_contrast_halves: assert property (
        !$stable(CONTRAST_LEVEL[5:4]) |-> $stable(CONTRAST_LEVEL[3:0]))
        else $error("both contrast halves changed together");
    a_busy_span: assert property (
        $fell(BUSY_FLAG) |-> busy_cnt_r == 8'h32)
        else $error("busy length wrong");
endmodule

// File: verification/lcdxid_host.sv
/* Host model: AHB-Lite master posting instructions and polling busy.
   Assumes the one slave's ready is fed back as hready. */
module lcdxid_host
(
    input  wire        clk,
    input  wire        hready,
    input  wire [31:0] hrdata,
    output reg         hsel,
    output reg  [31:0] haddr,
    output reg  [1:0]  htrans,
    output reg         hwrite,
    output reg  [2:0]  hsize,
    output reg  [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = 71'h0;
    task wait_rdy;
        integer n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1 && n < 64)
        begin
            n = n + 1;
            @(posedge clk);
        end
        if (hready !== 1'b1)
            testbench.fail_wait();
    endtask
    task xfer(input w, input [7:0] a, input [31:0] wd, output [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        wait_rdy();
        // Released lines show an inverse so a stale value cannot pass
        {hsel, htrans} <= 3'h0;
        haddr <= ~{24'h000000, a};
        hwdata <= w ? wd : ~wd;
        wait_rdy();
        rd = hrdata;
        hwdata <= ~wd;
    endtask
    task instr(input [9:0] v);
        reg [31:0] r;
        xfer(1'b1, 8'h00, {22'h0, v}, r);
    endtask
    task wait_idle;
        reg [31:0] r;
        integer n;
        n = 0;
        r = 32'h1;
        while (r[0] !== 1'b0 && n < 200)
        begin
            xfer(1'b0, 8'h08, 32'h0, r);
            n = n + 1;
        end
        if (r[0] !== 1'b0)
            testbench.fail_wait();
    endtask
endmodule

// File: verification/testbench.sv
/* Bench for the extended instruction decoder: random instructions through
   the host model, checked against a behavioural model after each one.
   Assumes the decoder, host model and checker are compiled first. */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam [71:0] FR_TBL = {9'h15B, 9'h112, 9'h0DD, 9'h0B7, 9'h0A1, 9'h090, 9'h083, 9'h07A};
    reg         CLK = 1'b0;
    reg         RST = 1'b1;
    reg         CLOCK_SOURCE_SELECT = 1'b1;
    reg         BIAS_OPTION_PIN_A = 1'b0;
    reg         BIAS_OPTION_PIN_B = 1'b0;
    wire        HSEL, HWRITE, HREADYOUT, HRESP, ICON_ENABLE, BOOSTER_ENABLE;
    wire        FOLLOWER_ENABLE, BUSY_FLAG;
    wire [31:0] HADDR, HWDATA, HRDATA;
    wire [1:0]  HTRANS;
    wire [2:0]  HSIZE, V0_GAIN_RATIO, OSC_TRIM_CODE;
    wire [5:0]  CONTRAST_LEVEL;
    wire [8:0]  FRAME_RATE_HZ;
    wire [3:0]  ICON_ADDRESS;
    integer     err_count = 0;
    integer     tests_run = 0;
    integer     b, i;
    reg  [31:0] lf = 32'h00002FDB;
    reg  [31:0] r;
    reg  [9:0]  v;
    reg         ex, ic, bo, fo;
    reg  [2:0]  ga, tr;
    reg  [1:0]  ch;
    reg  [3:0]  cl, ia;
    reg  [8:0]  fq;
    wire [31:0] seen = {3'h0, ICON_ENABLE, BOOSTER_ENABLE, FOLLOWER_ENABLE, V0_GAIN_RATIO,
                        CONTRAST_LEVEL, OSC_TRIM_CODE, ICON_ADDRESS, FRAME_RATE_HZ, BUSY_FLAG};
    wire        bz = !BIAS_OPTION_PIN_A && !BIAS_OPTION_PIN_B;
    always #10 CLK = ~CLK;
    lcdxid_decoder u_dut (.CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
        .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .CLOCK_SOURCE_SELECT,
        .BIAS_OPTION_PIN_A, .BIAS_OPTION_PIN_B, .ICON_ENABLE, .BOOSTER_ENABLE, .FOLLOWER_ENABLE,
        .V0_GAIN_RATIO, .CONTRAST_LEVEL, .OSC_TRIM_CODE, .FRAME_RATE_HZ, .ICON_ADDRESS, .BUSY_FLAG);
    lcdxid_host u_host (.clk(CLK), .hready(HREADYOUT), .hrdata(HRDATA), .hsel(HSEL),
        .haddr(HADDR), .htrans(HTRANS), .hwrite(HWRITE), .hsize(HSIZE), .hwdata(HWDATA));
    function [31:0] nx(input [31:0] s);
        nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input string nm, input [31:0] e, input [31:0] g);
        tests_run = tests_run + 1;
        if (g !== e)
        begin
            err_count = err_count + 1;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task cmp;
        chk("outputs", {3'h0, ic, bo, fo, ga, ch, cl, tr, ia, fq, 1'b0},
            seen);
    endtask
    task apply(input [9:0] w);
        if (w[9:8] == 2'h0 && w[7:5] == 3'h1)
            ex = w[0];
        else if (w[9:8] == 2'h0 && ex)
            case (w[7:4])
                4'h1: if (CLOCK_SOURCE_SELECT) tr = w[2:0];
                4'h4: ia = w[3:0];
                4'h5:
                begin
                    ic = w[3];
                    if (bz) {bo, ch} = w[2:0];
                end
                4'h6: if (bz) {fo, ga} = w[3:0];
                4'h7: if (bz) cl = w[3:0];
                default: ;
            endcase
        if (CLOCK_SOURCE_SELECT)
            fq = FR_TBL[tr * 9 +: 9];
    endtask
    task fail_wait;
        err_count = err_count + 1;
        summarize();
    endtask
    task summarize;
        if (err_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        {ex, ic, bo, fo, ga, ch, cl, tr, ia} = 20'h0;
        fq = 9'h07A;
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        repeat (2) @(posedge CLK);
        cmp();
        for (b = 0; b < 8; b = b + 1)
        begin
            lf = nx(lf);
            CLOCK_SOURCE_SELECT <= lf[2] | lf[3] | (b == 0);
            BIAS_OPTION_PIN_A <= lf[0] & lf[1] & (b != 0);
            BIAS_OPTION_PIN_B <= lf[4] & lf[5];
            repeat (6) @(posedge CLK);
            for (i = 0; i < 16; i = i + 1)
            begin
                lf = nx(lf);
                v = {lf[15:13] == 3'h0 ? lf[17:16] : 2'h0, 1'b0, lf[2:0], lf[7:4]};
                u_host.instr(v);
                u_host.wait_idle();
                apply(v);
                @(posedge CLK);
                cmp();
            end
        end
        u_host.instr(10'h021);
        u_host.wait_idle();
        apply(10'h021);
        // Second post lands while busy and must be dropped
        u_host.instr(10'h043);
        u_host.instr(10'h04C);
        u_host.wait_idle();
        apply(10'h043);
        @(posedge CLK);
        cmp();
        u_host.xfer(1'b0, 8'h08, 32'h0, r);
        chk("dropped count", 32'h1, {16'h0, r[31:16]});
        chk("bus response", 32'h0, {31'h0, HRESP});
        u_host.xfer(1'b1, 8'h14, lf, r);
        u_host.xfer(1'b0, 8'h14, 32'h0, r);
        chk("unmapped read", 32'h0, r);
        u_host.xfer(1'b0, 8'h0C, 32'h0, r);
        chk("analog reg", {20'h0, ch, cl, ga, fo, bo, ic}, r);
        u_host.xfer(1'b0, 8'h04, 32'h0, r);
        chk("ctrl reg", {31'h0, ex}, r);
        u_host.xfer(1'b0, 8'h10, 32'h0, r);
        chk("osc reg", {20'h0, fq, tr}, r);
        u_host.xfer(1'b0, 8'h00, 32'h0, r);
        chk("instr reg", 32'h00000043, r);
        summarize();
    end
endmodule
bind lcdxid_decoder lcdxid_assertions u_chk (.CLK, .RST, .CLOCK_SOURCE_SELECT,
    .BIAS_OPTION_PIN_A, .BIAS_OPTION_PIN_B, .ICON_ENABLE, .BOOSTER_ENABLE, .FOLLOWER_ENABLE,
    .V0_GAIN_RATIO, .CONTRAST_LEVEL, .OSC_TRIM_CODE, .FRAME_RATE_HZ, .ICON_ADDRESS, .BUSY_FLAG);
